/* File: sfd_pkg.sv */
package sfd_pkg;

  // Opcodes of the command set.
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_FORBID = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_READ_CONFIG = 8'h15;
  localparam logic [7:0] OP_ERASE_SECTOR = 8'h20;
  localparam logic [7:0] OP_READ_SEC = 8'h2B;
  localparam logic [7:0] OP_WRITE_SEC = 8'h2F;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h38;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_READ_PARAMS = 8'h5A;
  localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_BURST_B = 8'h77;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_READ_MFR = 8'h90;
  localparam logic [7:0] OP_RESET_MEM = 8'h99;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_ENTER_SECURE = 8'hB1;
  localparam logic [7:0] OP_DEEP_DOWN = 8'hB9;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_BURST_A = 8'hC0;
  localparam logic [7:0] OP_EXIT_SECURE = 8'hC1;
  localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_NOP = 8'h00;

  // Frame layout, security register bit positions and the hand-off buffer.
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SEC_REGION_BIT = 0;
  localparam int SEC_LOCK_BIT = 1;
  localparam int BUF_DEPTH = 4;
  localparam logic [1:0] PTR_RESET = 2'h0;

  typedef enum logic [4:0] {
    CMD_BAD, CMD_READ, CMD_READ_SEC, CMD_WRITE_ALLOW, CMD_WRITE_FORBID,
    CMD_WRITE_STATUS, CMD_PROGRAM, CMD_QUAD_PROGRAM, CMD_ERASE_SECTOR,
    CMD_ERASE_32K, CMD_ERASE_64K, CMD_ERASE_CHIP, CMD_DEEP_DOWN, CMD_RELEASE,
    CMD_SUSPEND, CMD_RESUME, CMD_ENTER_SECURE, CMD_EXIT_SECURE, CMD_WRITE_SEC,
    CMD_RESET_ARM, CMD_RESET_MEM, CMD_BURST, CMD_NOP
  } cmd_e;

  // Alternate codes fold onto one command; anything unlisted is CMD_BAD.
  function automatic cmd_e cmd_of(input logic [7:0] op);
    case (op)
      OP_READ, OP_FAST_READ, OP_DUAL_IO, OP_DUAL_OUT, OP_QUAD_IO, OP_QUAD_OUT,
      OP_READ_STATUS, OP_READ_CONFIG, OP_READ_ID, OP_READ_MFR,
      OP_READ_PARAMS: return CMD_READ;
      OP_READ_SEC: return CMD_READ_SEC;
      OP_WRITE_ALLOW: return CMD_WRITE_ALLOW;
      OP_WRITE_FORBID: return CMD_WRITE_FORBID;
      OP_WRITE_STATUS: return CMD_WRITE_STATUS;
      OP_PROGRAM: return CMD_PROGRAM;
      OP_QUAD_PROGRAM: return CMD_QUAD_PROGRAM;
      OP_ERASE_SECTOR: return CMD_ERASE_SECTOR;
      OP_ERASE_32K: return CMD_ERASE_32K;
      OP_ERASE_64K: return CMD_ERASE_64K;
      OP_ERASE_CHIP_A, OP_ERASE_CHIP_B: return CMD_ERASE_CHIP;
      OP_DEEP_DOWN: return CMD_DEEP_DOWN;
      OP_RELEASE: return CMD_RELEASE;
      OP_SUSPEND_A, OP_SUSPEND_B: return CMD_SUSPEND;
      OP_RESUME_A, OP_RESUME_B: return CMD_RESUME;
      OP_ENTER_SECURE: return CMD_ENTER_SECURE;
      OP_EXIT_SECURE: return CMD_EXIT_SECURE;
      OP_WRITE_SEC: return CMD_WRITE_SEC;
      OP_RESET_ARM: return CMD_RESET_ARM;
      OP_RESET_MEM: return CMD_RESET_MEM;
      OP_BURST_A, OP_BURST_B: return CMD_BURST;
      OP_NOP: return CMD_NOP;
      default: return CMD_BAD;
    endcase
  endfunction

  // Commands that are rejected unless chip select rises on a byte boundary.
  function automatic logic needs_align(input cmd_e c);
    return c inside {CMD_WRITE_ALLOW, CMD_WRITE_FORBID, CMD_WRITE_STATUS,
      CMD_PROGRAM, CMD_QUAD_PROGRAM, CMD_ERASE_SECTOR, CMD_ERASE_32K,
      CMD_ERASE_64K, CMD_ERASE_CHIP, CMD_SUSPEND, CMD_RESUME, CMD_NOP,
      CMD_RESET_ARM, CMD_RESET_MEM, CMD_ENTER_SECURE, CMD_EXIT_SECURE,
      CMD_WRITE_SEC};
  endfunction

  // Byte index of the first payload byte, zero when the command has none.
  function automatic logic [2:0] data_from(input cmd_e c);
    case (c)
      CMD_PROGRAM, CMD_QUAD_PROGRAM: return 3'h4;
      CMD_WRITE_STATUS, CMD_BURST: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  // Payload of these commands is only passed on while the latch is set.
  function automatic logic needs_latch(input cmd_e c);
    return c inside {CMD_PROGRAM, CMD_QUAD_PROGRAM, CMD_WRITE_STATUS};
  endfunction

endpackage

/* File: link_if.sv */
`timescale 1ns/1ns
interface link_if;
  import sfd_pkg::*;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [2:0] bit_phase;
  logic [2:0] byte_cnt;
  logic frame_tog;
  logic [1:0] wr_gray;
  logic [7:0] buf_data [BUF_DEPTH];
  logic [7:0] sec_value;
  modport link (output opcode, addr, bit_phase, byte_cnt, frame_tog, wr_gray,
    buf_data, input sec_value);
  modport core (input opcode, addr, bit_phase, byte_cnt, frame_tog, wr_gray,
    buf_data, output sec_value);
endinterface

/* File: sfd_link_shift.sv */
`timescale 1ns/1ns
module sfd_link_shift (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rst,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  link_if.link lk
);
  import sfd_pkg::*;

  logic idle;
  logic first;
  logic [6:0] part;
  logic [1:0] wbin;
  logic [7:0] nb;
  logic push;
  logic [2:0] pb;
  logic [2:0] pc;
  logic [6:0] next_part;
  logic [2:0] next_phase;
  logic [2:0] next_count;
  logic [7:0] next_opcode;
  logic [23:0] next_addr;
  logic [1:0] next_wbin;
  logic [1:0] next_wgray;
  logic next_tog;
  logic next_so;
  logic next_oe_n;

  // Chip select high presets the frame-start flag and releases the output; counts and captured
  // bytes survive so the system clock side can judge the frame afterwards.
  assign idle = cs_n | rst;

  //////////////////////////////////////////////////////////////////////////
  // Input shifting on the rising sclk edge.
  always_comb begin
    pb = first ? 3'h0 : lk.bit_phase;
    pc = first ? 3'h0 : lk.byte_cnt;
    nb = {(first ? 7'h00 : part), si};
    next_part = nb[6:0];
    next_phase = pb + 3'h1;
    next_count = pc;
    next_opcode = lk.opcode;
    next_addr = lk.addr;
    next_wbin = wbin;
    next_tog = first ? ~lk.frame_tog : lk.frame_tog;
    push = 1'b0;
    if (pb == LAST_BIT) begin
      if (pc != BYTE_CNT_MAX) next_count = pc + 3'h1;
      if (pc == 3'h0) begin
        next_opcode = nb;
      end else begin
        if (pc <= ADDR_BYTES) next_addr = {lk.addr[15:0], nb};
        // Payload goes to the hand-off buffer only for known commands.
        if (data_from(cmd_of(lk.opcode)) != 3'h0 &&
            pc >= data_from(cmd_of(lk.opcode))) push = 1'b1;
      end
    end
    next_wbin = push ? wbin + 2'h1 : wbin;
    next_wgray = next_wbin ^ {1'b0, next_wbin[1]};
  end

  // The frame-start flag is preset by chip select, a constant only.
  always_ff @(posedge sclk or posedge idle) begin
    if (idle) first <= 1'b1;
    else first <= 1'b0;
  end

  // Frame counters and captured bytes.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      part <= 7'h00;
      lk.bit_phase <= 3'h0;
      lk.byte_cnt <= 3'h0;
      lk.opcode <= OP_NOP;
      lk.addr <= 24'h000000;
      lk.frame_tog <= 1'b0;
      wbin <= PTR_RESET;
      lk.wr_gray <= PTR_RESET;
    end else begin
      part <= next_part;
      lk.bit_phase <= next_phase;
      lk.byte_cnt <= next_count;
      lk.opcode <= next_opcode;
      lk.addr <= next_addr;
      lk.frame_tog <= next_tog;
      wbin <= next_wbin;
      lk.wr_gray <= next_wgray;
    end
  end

  // Buffer slots hold data only; the gray pointer says which are valid.
  always_ff @(posedge sclk) begin
    if (push) lk.buf_data[wbin] <= nb;
  end

  //////////////////////////////////////////////////////////////////////////
  // Output on the falling edge; only the security register read drives the
  // pin, so an unknown opcode leaves it released until the next frame.
  always_comb begin
    next_so = lk.sec_value[3'h7 - lk.bit_phase];
    next_oe_n = !(!first && lk.byte_cnt != 3'h0 &&
                  cmd_of(lk.opcode) == CMD_READ_SEC);
  end

  always_ff @(negedge sclk or posedge idle) begin
    if (idle) begin
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      so <= next_so;
      so_oe_n <= next_oe_n;
    end
  end

  a_standby_hiz: assert property (@(negedge sclk) disable iff (idle)
    lk.byte_cnt != 3'h0 && cmd_of(lk.opcode) == CMD_BAD |=> so_oe_n)
    else $error("output driven after unknown opcode");
  a_secreg_bits: assert property (@(negedge sclk) disable iff (idle)
    !so_oe_n |-> so == lk.sec_value[3'h7 - $past(lk.bit_phase)])
    else $error("security register bit out of order");

endmodule // sfd_link_shift

/* File: sfd_command_decoder.sv */
`timescale 1ns/1ns
//
// Behaviour
// - Page program takes three address bytes, high first, then page data.
// - Security register read shifts out the register with no address.
// - Enter-secure-region redirects array accesses to the secured area.
// - Exit-secure-region returns accesses to the normal array.
// - Memory reset runs only directly after an accepted reset-arm.
// - Any other command after reset-arm drops the armed state.
// - Listed commands need chip select to rise on a byte boundary.
// - Unknown opcode: output released until next chip select fall.
// - Program and erase need the write latch set beforehand.
// - Latch clears at reset and after the listed completed commands.
module sfd_command_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  output logic exec_valid,
  output sfd_pkg::cmd_e exec_cmd,
  output logic [23:0] exec_addr,
  output logic write_latch,
  output logic secure_region,
  output logic data_valid,
  output logic [7:0] data_byte
);
  import sfd_pkg::*;

  link_if lk ();

  logic cs_s1, cs_s2, cs_s3;
  logic tog_s1, tog_s2, seen_tog;
  logic [1:0] wg_s1, wg_s2;
  logic [1:0] rbin;
  logic [1:0] wbin_s;
  logic armed;
  logic lock;
  logic frame_end;
  cmd_e cmd;
  logic aligned;
  logic ok;
  logic fire;
  logic next_seen;
  logic next_latch, next_secure, next_armed, next_lock;
  logic next_exec_valid;
  cmd_e next_exec_cmd;
  logic [23:0] next_exec_addr;
  logic [1:0] next_rbin;
  logic next_data_valid;
  logic [7:0] next_data_byte;

  //////////////////////////////////////////////////////////////////////////
  // Link side: shifting and serial output run on sclk.
  sfd_link_shift u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .rst(rst),
    .si(si),
    .so(so),
    .so_oe_n(so_oe_n),
    .lk(lk.link)
  );

  // The security register changes only between frames, so the link reads
  // it as a quiet word; the host must keep chip select high a few clocks.
  always_comb begin
    lk.sec_value = 8'h00;
    lk.sec_value[SEC_REGION_BIT] = secure_region;
    lk.sec_value[SEC_LOCK_BIT] = lock;
  end

  //////////////////////////////////////////////////////////////////////////
  // Crossings: chip select and frame toggle as levels, the write pointer
  // as gray code. Logic reads the second stage, and cs_s3 as well for chip select.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      wg_s1 <= PTR_RESET;
      wg_s2 <= PTR_RESET;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tog_s1 <= lk.frame_tog;
      tog_s2 <= tog_s1;
      wg_s1 <= lk.wr_gray;
      wg_s2 <= wg_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame judgement. A chip select pulse with no clocks leaves the toggle
  // unchanged and so cannot replay the previous frame.
  always_comb begin
    frame_end = cs_s2 && !cs_s3 && (tog_s2 != seen_tog);
    next_seen = frame_end ? tog_s2 : seen_tog;
    cmd = cmd_of(lk.opcode);
    aligned = lk.bit_phase == 3'h0 && lk.byte_cnt != 3'h0;
    ok = lk.byte_cnt != 3'h0 && (aligned || !needs_align(cmd));
  end

  // Command effects at the end of a frame.
  always_comb begin
    fire = 1'b0;
    next_latch = write_latch;
    next_secure = secure_region;
    next_armed = armed;
    next_lock = lock;
    next_exec_valid = 1'b0;
    next_exec_cmd = exec_cmd;
    next_exec_addr = exec_addr;
    if (frame_end) begin
      next_armed = 1'b0;
      if (ok) begin
        case (cmd)
          CMD_WRITE_ALLOW: next_latch = 1'b1;
          CMD_WRITE_FORBID: next_latch = 1'b0;
          CMD_PROGRAM, CMD_QUAD_PROGRAM, CMD_ERASE_SECTOR, CMD_ERASE_32K,
          CMD_ERASE_64K: begin
            // Address commands also need all three address bytes.
            if (write_latch && lk.byte_cnt > ADDR_BYTES) begin
              fire = 1'b1;
              next_latch = 1'b0;
            end
          end
          CMD_ERASE_CHIP, CMD_WRITE_STATUS: begin
            if (write_latch) begin
              fire = 1'b1;
              next_latch = 1'b0;
            end
          end
          CMD_WRITE_SEC: begin
            if (write_latch) begin
              fire = 1'b1;
              next_lock = 1'b1;
              next_latch = 1'b0;
            end
          end
          CMD_SUSPEND: begin
            fire = 1'b1;
            next_latch = 1'b0;
          end
          CMD_RESUME, CMD_DEEP_DOWN, CMD_RELEASE, CMD_BURST: fire = 1'b1;
          CMD_ENTER_SECURE: next_secure = 1'b1;
          CMD_EXIT_SECURE: next_secure = 1'b0;
          CMD_RESET_ARM: next_armed = 1'b1;
          CMD_RESET_MEM: begin
            if (armed) begin
              fire = 1'b1;
              next_latch = 1'b0;
              next_secure = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    if (fire) begin
      next_exec_valid = 1'b1;
      next_exec_cmd = cmd;
      next_exec_addr = lk.addr;
    end
  end

  // Payload hand-off: one byte per clock while the buffer is not empty.
  // Latch-gated payload is dropped when the latch is clear.
  always_comb begin
    wbin_s = {wg_s2[1], wg_s2[1] ^ wg_s2[0]};
    next_rbin = rbin;
    next_data_valid = 1'b0;
    next_data_byte = data_byte;
    if (wbin_s != rbin) begin
      next_rbin = rbin + 2'h1;
      next_data_byte = lk.buf_data[rbin];
      next_data_valid = !needs_latch(cmd) || write_latch;
    end
  end

  // State registers; the latch starts cleared.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_tog <= 1'b0;
      write_latch <= 1'b0;
      secure_region <= 1'b0;
      armed <= 1'b0;
      lock <= 1'b0;
      exec_valid <= 1'b0;
      exec_cmd <= CMD_NOP;
      exec_addr <= 24'h000000;
      rbin <= PTR_RESET;
      data_valid <= 1'b0;
      data_byte <= 8'h00;
    end else begin
      seen_tog <= next_seen;
      write_latch <= next_latch;
      secure_region <= next_secure;
      armed <= next_armed;
      lock <= next_lock;
      exec_valid <= next_exec_valid;
      exec_cmd <= next_exec_cmd;
      exec_addr <= next_exec_addr;
      rbin <= next_rbin;
      data_valid <= next_data_valid;
      data_byte <= next_data_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks on the decoded behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_done(cmd_e c);
    frame_end && ok && cmd == c;
  endsequence

  sequence s_bad_end;
    frame_end && !ok;
  endsequence

  a_allow_sets: assert property (
    s_done(CMD_WRITE_ALLOW) |=> write_latch)
    else $error("write allow did not set latch");
  a_latch_gates: assert property (
    exec_valid && exec_cmd inside
    {CMD_PROGRAM, CMD_ERASE_SECTOR, CMD_ERASE_CHIP} |-> $past(write_latch))
    else $error("program or erase without latch");
  a_latch_clears: assert property (
    exec_valid && exec_cmd inside
    {CMD_PROGRAM, CMD_SUSPEND, CMD_WRITE_SEC} |-> !write_latch)
    else $error("latch not cleared after command");
  a_reset_armed: assert property (
    exec_valid && exec_cmd == CMD_RESET_MEM |-> $past(armed, 2))
    else $error("memory reset without arm");
  a_arm_dropped: assert property (
    frame_end && cmd != CMD_RESET_ARM |=> !armed)
    else $error("arm kept after other command");
  a_secure_enter: assert property (
    s_done(CMD_ENTER_SECURE) |=> secure_region ##1 secure_region)
    else $error("secure region not entered");
  a_secure_exit: assert property (
    s_done(CMD_EXIT_SECURE) |=> !secure_region)
    else $error("secure region not left");
  a_misaligned_reject: assert property (
    s_bad_end |=> !exec_valid && $stable(write_latch))
    else $error("misaligned command executed");
  a_program_addr: assert property (
    s_done(CMD_PROGRAM) && write_latch && lk.byte_cnt > ADDR_BYTES
    |=> exec_valid && exec_addr == $past(lk.addr))
    else $error("program address not passed");

endmodule // sfd_command_decoder

/* File: spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic [7:0] rx;
  int oe_cnt;

  // The serial clock stands still low between frames, as a mode 0 host does.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first. The second byte slot is captured from so, and the
  // number of those bits seen with the output driven is counted.
  // A caller may stop mid-byte on purpose; otherwise frames end on bytes.
  task automatic frame(input logic [7:0] b [8], input int nbits,
    input int slow);
    int i;
    rx = 8'h00;
    oe_cnt = 0;
    #1 cs_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      si = b[i / 8][7 - i % 8];
      #(3 + slow) sclk = 1'b1;
      if (i >= 8 && i < 16) begin
        rx = {rx[6:0], so};
        if (so_oe_n === 1'b0) oe_cnt++;
      end
      #(3 + slow) sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    // A released data line must not keep looking valid.
    si = ~si;
  endtask
endmodule // spi_host_model

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  import sfd_pkg::*;
  logic clk, rst, sclk, cs_n, si, so, so_oe_n, exec_valid;
  logic write_latch, secure_region, data_valid;
  cmd_e exec_cmd, ex_cmd;
  logic [23:0] exec_addr, ex_addr, a;
  logic [7:0] data_byte, d0, d1;
  logic [7:0] fb [8];
  logic [7:0] ops [8];
  cmd_e exps [8];
  logic [7:0] bad [3];
  logic [7:0] dq [$];
  int err_count, tests_run, ex_cnt, seed, i, n;

  sfd_command_decoder dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .si(si), .so(so), .so_oe_n(so_oe_n), .exec_valid(exec_valid),
    .exec_cmd(exec_cmd), .exec_addr(exec_addr), .write_latch(write_latch),
    .secure_region(secure_region), .data_valid(data_valid),
    .data_byte(data_byte));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n));

  // The system clock toggles every 10 ns, a period of 20 ns.
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Executed commands and payload bytes are logged for later comparison.
  always @(posedge clk) begin
    if (exec_valid === 1'b1) begin
      ex_cnt++;
      ex_cmd = exec_cmd;
      ex_addr = exec_addr;
    end
    if (data_valid === 1'b1) dq.push_back(data_byte);
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // The gap after each frame covers the judging delay and the idle time.
  task automatic send(input int nbits, input int slow);
    host.frame(fb, nbits, slow);
    repeat (10) @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] op);
    fb[0] = op;
    send(8, 0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    seed = 59;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("latch at reset", write_latch, 0);
    check("secure at reset", secure_region, 0);
    check("oe at reset", so_oe_n, 1);
    check("cmd at reset", exec_cmd, CMD_NOP);
    // A program without a prior allow must do nothing.
    n = ex_cnt;
    fb = '{OP_PROGRAM, 8'h12, 8'h34, 8'h56, 8'h9A, 8'h00, 8'h00, 8'h00};
    send(40, 0);
    check("unlatched program", ex_cnt, n);
    check("unlatched payload", dq.size(), 0);
    // An allow that stops one bit past the byte is refused.
    fb[0] = OP_WRITE_ALLOW;
    send(9, 0);
    check("misaligned allow", write_latch, 0);
    // Random programs; the last one ends mid-byte and must be refused.
    for (i = 0; i < 4; i++) begin
      cmd(OP_WRITE_ALLOW);
      check("allow latch", write_latch, 1);
      a = $random(seed);
      d0 = $random(seed);
      d1 = $random(seed);
      fb = '{OP_PROGRAM, a[23:16], a[15:8], a[7:0], d0, d1, 8'h00, 8'h00};
      dq.delete();
      n = ex_cnt;
      send(i == 3 ? 51 : 48, i % 2);
      if (i == 3) begin
        check("cut program", ex_cnt, n);
        check("cut keeps latch", write_latch, 1);
      end else begin
        check("program exec", ex_cnt, n + 1);
        check("program cmd", ex_cmd, CMD_PROGRAM);
        check("program addr", ex_addr, a);
        check("payload count", dq.size(), 2);
        check("payload 0", dq[0], d0);
        check("payload 1", dq[1], d1);
        check("latch after program", write_latch, 0);
      end
    end
    cmd(OP_WRITE_FORBID);
    check("forbid latch", write_latch, 0);
    // Secure region entry, register read back, exit.
    cmd(OP_ENTER_SECURE);
    check("secure on", secure_region, 1);
    fb[0] = OP_READ_SEC;
    send(16, 1);
    check("sec read value", host.rx, 8'h01);
    check("sec read driven", host.oe_cnt, 8);
    cmd(OP_EXIT_SECURE);
    check("secure off", secure_region, 0);
    // Unknown codes are sent here on purpose, against host practice.
    bad = '{8'hFF, 8'hA5, 8'h12};
    for (i = 0; i < 3; i++) begin
      n = ex_cnt;
      fb[0] = bad[i];
      send(16, 0);
      check("unknown released", host.oe_cnt, 0);
      check("unknown no exec", ex_cnt, n);
    end
    // An arm broken by another command leaves the reset ignored.
    cmd(OP_ENTER_SECURE);
    cmd(OP_RESET_ARM);
    cmd(OP_NOP);
    cmd(OP_RESET_MEM);
    check("disarmed reset", secure_region, 1);
    cmd(OP_WRITE_ALLOW);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_MEM);
    check("reset secure", secure_region, 0);
    check("reset latch", write_latch, 0);
    // Each alternate code must act as its twin.
    ops = '{OP_ERASE_CHIP_A, OP_ERASE_CHIP_B, OP_SUSPEND_A, OP_SUSPEND_B,
      OP_RESUME_A, OP_RESUME_B, OP_BURST_A, OP_BURST_B};
    exps = '{CMD_ERASE_CHIP, CMD_ERASE_CHIP, CMD_SUSPEND, CMD_SUSPEND,
      CMD_RESUME, CMD_RESUME, CMD_BURST, CMD_BURST};
    for (i = 0; i < 8; i++) begin
      cmd(OP_WRITE_ALLOW);
      n = ex_cnt;
      cmd(ops[i]);
      check("alt exec", ex_cnt, n + 1);
      check("alt cmd", ex_cmd, exps[i]);
    end
    // A security write sets the lock bit, seen on the next register read.
    cmd(OP_WRITE_ALLOW);
    cmd(OP_WRITE_SEC);
    check("latch after sec write", write_latch, 0);
    fb[0] = OP_READ_SEC;
    send(16, 0);
    check("sec read lock", host.rx, 8'h02);
    complete_run();
  end
endmodule // tb
